/* File: bench/dsg_pin_model.sv */
/*
  pad model for one port: resolves the level seen on each pin.
  assumes the bench sets what the outside party drives.
*/
`timescale 1ns/1ps
module dsg_pin_model #(
  parameter int W = 3
) (
  input wire logic [W-1:0] drv, // design drive value
  input wire logic [W-1:0] oe, // design drive enable
  input wire logic [W-1:0] ext, // outside drive value
  output logic [W-1:0] lvl // resolved pin level
);
  // an undriven pin follows the outside party, never a held value
  assign lvl = (oe & drv) | (~oe & ext);
endmodule

/* File: bench/dsg_ports_tb.sv */
/*
  self checking bench for the dual gpio ports, random with fixed seed.
  assumes the design files and the pin model compile first.
*/
`timescale 1ns/1ps
`include "dsg_cfg.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("wrong value %s exp %h got %h", n, e, g); err_total++; end end
module dsg_ports_tb;
  // one aligned word per register: byte address is four times the index
  localparam logic [11:0] adr_gl = 12'(`DSG_OFF_FIRST_LATCH * 4);
  localparam logic [11:0] adr_hl = 12'(`DSG_OFF_SECOND_LATCH * 4);
  localparam logic [11:0] adr_gd = 12'(`DSG_OFF_FIRST_DIR * 4);
  localparam logic [11:0] adr_hd = 12'(`DSG_OFF_SECOND_DIR * 4);
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic pready, pslverr, err;
  logic [4:0] key = 5'h00;
  logic [4:0] kp;
  logic [2:0] pg_exp, ph_exp;
  logic [2:0] g_out, g_oe, g_in, lg, dg;
  logic [2:0] g_ext = 3'h0;
  logic [1:0] h_out, h_oe, h_in, lh, dh;
  logic [1:0] h_ext = 2'h0;
  int err_total = 0;
  int compares = 0;
  always #25 clk = ~clk;
  dsg_ports uut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_wake_irq_enable(key), .first_pin_in(g_in), .first_pin_out(g_out),
    .first_pin_oe(g_oe), .second_pin_in(h_in), .second_pin_out(h_out),
    .second_pin_oe(h_oe), .key_wake_pins(kp));
  dsg_pin_model #(.W(3)) pg (.drv(g_out), .oe(g_oe), .ext(g_ext), .lvl(g_in));
  dsg_pin_model #(.W(2)) ph (.drv(h_out), .oe(h_oe), .ext(h_ext), .lvl(h_in));
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  function automatic logic [2:0] pin_lvl(input logic [2:0] lat,
    input logic [2:0] dir, input logic [2:0] kb, input logic [2:0] ext);
    // the latch reaches the pin only where output is chosen and no key
    // enable has taken it over; elsewhere the outside level shows
    pin_lvl = (lat & dir & ~kb) | (ext & ~(dir & ~kb));
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task check_all;
    apb(1'b0, adr_gl, 32'h0);
    `CHK("g_data", {29'h0, (lg & dg) | (g_ext & ~dg)}, rd)
    `CHK("g_err", 1'b0, err)
    apb(1'b0, adr_hl, 32'h0);
    `CHK("h_data", {30'h0, (lh & dh) | (h_ext & ~dh)}, rd)
    apb(1'b0, adr_gd, 32'h0);
    `CHK("g_dir", {29'h0, dg}, rd)
    apb(1'b0, adr_hd, 32'h0);
    `CHK("h_dir", {30'h0, dh}, rd)
    `CHK("g_oe", dg & ~key[2:0], g_oe)
    `CHK("h_oe", dh & ~key[4:3], h_oe)
    `CHK("g_out", lg, g_out)
    `CHK("h_out", lh, h_out)
    pg_exp = pin_lvl(lg, dg, key[2:0], g_ext);
    ph_exp = pin_lvl({1'b0, lh}, {1'b0, dh}, {1'b0, key[4:3]},
      {1'b0, h_ext});
    `CHK("pins", {ph_exp[1:0], pg_exp}, kp)
  endtask
  task stop_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(87583));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, adr_gd, 32'h0);
    `CHK("g_dir_rst", 32'h0, rd)
    apb(1'b0, adr_hd, 32'h0);
    `CHK("h_dir_rst", 32'h0, rd)
    `CHK("oe_rst", 5'h00, {h_oe, g_oe})
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      key <= i[0] ? 5'($urandom) : 5'h00;
      g_ext <= 3'($urandom);
      h_ext <= 2'($urandom);
      // latch before direction so a new output never glitches
      d = $urandom;
      lg = d[2:0];
      apb(1'b1, adr_gl, d);
      d = $urandom;
      lh = d[1:0];
      apb(1'b1, adr_hl, d);
      d = $urandom;
      dg = d[2:0];
      apb(1'b1, adr_gd, d);
      d = $urandom;
      dh = d[1:0];
      apb(1'b1, adr_hd, d);
      check_all;
    end
    $display("test random done");
    apb(1'b1, 12'h030, 32'hffffffff);
    apb(1'b0, 12'h030, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    $display("test unmapped done");
    // second reset mid run: latches must survive it
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    dg = 3'h0;
    dh = 2'h0;
    check_all;
    $display("test second reset done");
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    stop_test;
  end
endmodule

/* File: logic/dsg_cfg.svh */
/*
  register offsets, field positions and reset values of the dual gpio ports.
  assumes inclusion by bare name from the testbench and the design module.
*/
`ifndef DSG_CFG_SVH
`define DSG_CFG_SVH
`define DSG_FIRST_WIDTH 3
`define DSG_SECOND_WIDTH 2
`define DSG_OFF_FIRST_LATCH 12'h00a
`define DSG_OFF_SECOND_LATCH 12'h00b
`define DSG_OFF_FIRST_DIR 12'h00e
`define DSG_OFF_SECOND_DIR 12'h00f
`define DSG_DIR_RESET 8'h00
`define DSG_KEY_FIRST_LSB 0
`define DSG_KEY_SECOND_LSB 3
`define DSG_KEY_WIDTH 5
`endif

/* File: logic/dsg_pkg.sv */
/*
  types shared by the dual gpio port design.
  assumes the constants header sits beside it.
*/
package dsg_pkg;
  typedef enum logic [2:0] {
    DSG_SEL_NONE,
    DSG_SEL_FIRST_LATCH,
    DSG_SEL_SECOND_LATCH,
    DSG_SEL_FIRST_DIR,
    DSG_SEL_SECOND_DIR
  } dsg_sel_e;
endpackage

/* File: logic/dsg_ports.sv */
/*
  two small general purpose ports with per pin latch and direction,
  reached over apb; key wake enables take pins over as inputs.
  assumes pins synchronous to clk and an outside pad resolving the enables.
*/
// Summary of operation
// - first port has three latch bits, untouched by reset.
// - second port has two latch bits, untouched by reset.
// - first port direction one drives the pin, zero leaves it input.
// - second port direction one drives the pin, zero leaves it input.
// - reset clears first port direction bits, all pins inputs.
// - reset clears second port direction bits, all pins inputs.
// - first data read gives latch where the direction bit is one, pin level where it is zero.
// - second data read gives latch where the direction bit is one, pin level where it is zero.
// - latches accept writes whatever the direction bits hold.
// - writing the latch of a direction zero pin changes neither pin nor read value.
// - key wake enable on a first port pin forces it to input.
// - key wake enables four and three force second port pins to input.
// - first direction register uses bits 2..0, upper bits read zero.
// - second direction register uses bits 1..0, upper bits read zero.
`timescale 1ns/1ps
`include "dsg_cfg.svh"
module dsg_ports #(
  parameter int FW = `DSG_FIRST_WIDTH,
  parameter int SW = `DSG_SECOND_WIDTH
) (
  input wire logic clk, // 20 mhz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready, always high
  output logic pslverr, // apb error on unmapped address
  input wire logic [`DSG_KEY_WIDTH-1:0] key_wake_irq_enable, // key enables
  input wire logic [FW-1:0] first_pin_in, // first port pin levels
  output logic [FW-1:0] first_pin_out, // first port drive value
  output logic [FW-1:0] first_pin_oe, // first port drive enable
  input wire logic [SW-1:0] second_pin_in, // second port pin levels
  output logic [SW-1:0] second_pin_out, // second port drive value
  output logic [SW-1:0] second_pin_oe, // second port drive enable
  output logic [`DSG_KEY_WIDTH-1:0] key_wake_pins // pin levels to key logic
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  dsg_pkg::dsg_sel_e sel;
  logic wr_en;
  logic rd_en;
  logic [FW-1:0] first_latch_ff;
  logic [SW-1:0] second_latch_ff;
  logic [FW-1:0] first_dir_ff;
  logic [SW-1:0] second_dir_ff;
  logic [FW-1:0] first_key;
  logic [SW-1:0] second_key;
  logic [31:0] nxt_prdata;

  // offsets are register indices; each register takes one aligned word,
  // so its byte address is four times the index
  function automatic logic [11:0] reg_byte_addr(input logic [11:0] idx);
    reg_byte_addr = {idx[9:0], 2'b00};
  endfunction

  always_comb begin
    case (paddr)
      reg_byte_addr(`DSG_OFF_FIRST_LATCH):
        sel = dsg_pkg::DSG_SEL_FIRST_LATCH;
      reg_byte_addr(`DSG_OFF_SECOND_LATCH):
        sel = dsg_pkg::DSG_SEL_SECOND_LATCH;
      reg_byte_addr(`DSG_OFF_FIRST_DIR):
        sel = dsg_pkg::DSG_SEL_FIRST_DIR;
      reg_byte_addr(`DSG_OFF_SECOND_DIR):
        sel = dsg_pkg::DSG_SEL_SECOND_DIR;
      default: sel = dsg_pkg::DSG_SEL_NONE;
    endcase
  end

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pslverr = psel && penable && (sel == dsg_pkg::DSG_SEL_NONE);

  // ---------------------------------------------------------------
  // data latches, no reset
  // ---------------------------------------------------------------
  // latches hold whatever they had; reset leaves them alone on purpose
  always_ff @(posedge clk) begin
    if (wr_en && sel == dsg_pkg::DSG_SEL_FIRST_LATCH) begin
      first_latch_ff <= pwdata[FW-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en && sel == dsg_pkg::DSG_SEL_SECOND_LATCH) begin
      second_latch_ff <= pwdata[SW-1:0];
    end
  end

  // ---------------------------------------------------------------
  // direction registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_dir_ff <= FW'(`DSG_DIR_RESET);
    end else if (wr_en && sel == dsg_pkg::DSG_SEL_FIRST_DIR) begin
      first_dir_ff <= pwdata[FW-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      second_dir_ff <= SW'(`DSG_DIR_RESET);
    end else if (wr_en && sel == dsg_pkg::DSG_SEL_SECOND_DIR) begin
      second_dir_ff <= pwdata[SW-1:0];
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  assign first_key = key_wake_irq_enable[`DSG_KEY_FIRST_LSB +: FW];
  assign second_key = key_wake_irq_enable[`DSG_KEY_SECOND_LSB +: SW];

  // a key wake enable wins over the direction bit
  assign first_pin_oe = first_dir_ff & ~first_key;
  assign second_pin_oe = second_dir_ff & ~second_key;
  // drive value is the latch alone, not gated by the enable; the outside pad keeps it off input pins
  assign first_pin_out = first_latch_ff;
  assign second_pin_out = second_latch_ff;
  assign key_wake_pins = {second_pin_in, first_pin_in};

  // read select follows the direction bit even where a key enable took
  // the pin over, as the port read path is unaware of the key logic
  function automatic logic [7:0] mix_read(input logic [7:0] dir,
                                          input logic [7:0] lat,
                                          input logic [7:0] pin);
    mix_read = (dir & lat) | (~dir & pin);
  endfunction

  // ---------------------------------------------------------------
  // read data, registered in the setup cycle
  // ---------------------------------------------------------------
  always_comb begin
    nxt_prdata = 32'h0;
    case (sel)
      dsg_pkg::DSG_SEL_FIRST_LATCH:
        nxt_prdata[7:0] = mix_read(8'(first_dir_ff), 8'(first_latch_ff),
                                   8'(first_pin_in));
      dsg_pkg::DSG_SEL_SECOND_LATCH:
        nxt_prdata[7:0] = mix_read(8'(second_dir_ff), 8'(second_latch_ff),
                                   8'(second_pin_in));
      dsg_pkg::DSG_SEL_FIRST_DIR:
        nxt_prdata[7:0] = 8'(first_dir_ff);
      dsg_pkg::DSG_SEL_SECOND_DIR:
        nxt_prdata[7:0] = 8'(second_dir_ff);
      default: nxt_prdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      prdata <= nxt_prdata;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_first_dir_wr;
    wr_en && sel == dsg_pkg::DSG_SEL_FIRST_DIR;
  endsequence

  property p_first_reset;
    @(posedge clk) !rst_n |=> first_dir_ff == '0;
  endproperty
  a_first_reset: assert property (p_first_reset)
    else $error("first direction not cleared by reset");

  property p_second_reset;
    @(posedge clk) !rst_n |=> second_dir_ff == '0 && second_pin_oe == '0;
  endproperty
  a_second_reset: assert property (p_second_reset)
    else $error("second direction not cleared by reset");

  property p_first_dir_wr;
    @(posedge clk) disable iff (!rst_n)
      s_first_dir_wr |=> first_dir_ff == $past(pwdata[FW-1:0]);
  endproperty
  a_first_dir_wr: assert property (p_first_dir_wr)
    else $error("first direction write lost");

  property p_first_oe;
    @(posedge clk) disable iff (!rst_n)
      first_pin_oe == (first_dir_ff & ~first_key);
  endproperty
  a_first_oe: assert property (p_first_oe)
    else $error("first port enable wrong");

  property p_key_over;
    @(posedge clk) disable iff (!rst_n)
      second_key[0] |-> !second_pin_oe[0];
  endproperty
  a_key_over: assert property (p_key_over)
    else $error("key enable did not force input");

  property p_latch_wr;
    @(posedge clk) disable iff (!rst_n)
      wr_en && sel == dsg_pkg::DSG_SEL_FIRST_LATCH
      |=> first_pin_out == $past(pwdata[FW-1:0]);
  endproperty
  a_latch_wr: assert property (p_latch_wr)
    else $error("latch write lost");

  property p_read_first;
    @(posedge clk) disable iff (!rst_n)
      rd_en && sel == dsg_pkg::DSG_SEL_FIRST_LATCH |=>
      prdata[FW-1:0] == (($past(first_dir_ff) & $past(first_latch_ff)) |
        (~$past(first_dir_ff) & $past(first_pin_in)));
  endproperty
  a_read_first: assert property (p_read_first)
    else $error("first port read mixes wrong");

  property p_read_upper;
    @(posedge clk) disable iff (!rst_n)
      rd_en |=> prdata[31:FW] == '0;
  endproperty
  a_read_upper: assert property (p_read_upper)
    else $error("upper read bits not zero");

  sequence s_second_dir_wr;
    wr_en && sel == dsg_pkg::DSG_SEL_SECOND_DIR;
  endsequence

  sequence s_first_latch_wr;
    wr_en && sel == dsg_pkg::DSG_SEL_FIRST_LATCH;
  endsequence

  sequence s_second_latch_wr;
    wr_en && sel == dsg_pkg::DSG_SEL_SECOND_LATCH;
  endsequence

  property p_second_dir_wr;
    @(posedge clk) disable iff (!rst_n)
      s_second_dir_wr |=> second_dir_ff == $past(pwdata[SW-1:0]);
  endproperty
  a_second_dir_wr: assert property (p_second_dir_wr)
    else $error("second direction write lost");

  property p_second_latch_wr;
    @(posedge clk) disable iff (!rst_n)
      s_second_latch_wr |=> second_pin_out == $past(pwdata[SW-1:0]);
  endproperty
  a_second_latch_wr: assert property (p_second_latch_wr)
    else $error("second latch write lost");

  // a latch write must not touch direction, so an input pin keeps
  // showing the outside level after it
  property p_first_keeps_dir;
    @(posedge clk) disable iff (!rst_n)
      s_first_latch_wr |=> first_dir_ff == $past(first_dir_ff);
  endproperty
  a_first_keeps_dir: assert property (p_first_keeps_dir)
    else $error("first latch write moved direction");

  property p_second_keeps_dir;
    @(posedge clk) disable iff (!rst_n)
      s_second_latch_wr |=> second_dir_ff == $past(second_dir_ff);
  endproperty
  a_second_keeps_dir: assert property (p_second_keeps_dir)
    else $error("second latch write moved direction");

  property p_unmapped_wr;
    @(posedge clk) disable iff (!rst_n)
      wr_en && sel == dsg_pkg::DSG_SEL_NONE |=>
      first_dir_ff == $past(first_dir_ff) &&
      second_dir_ff == $past(second_dir_ff);
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr)
    else $error("write to unmapped address landed");

  property p_first_key_over;
    @(posedge clk) disable iff (!rst_n)
      (first_key & first_pin_oe) == '0;
  endproperty
  a_first_key_over: assert property (p_first_key_over)
    else $error("key enable left a first port pin driven");

  property p_second_key_hi;
    @(posedge clk) disable iff (!rst_n)
      second_key[1] |-> !second_pin_oe[1];
  endproperty
  a_second_key_hi: assert property (p_second_key_hi)
    else $error("key enable did not force second pin input");

  property p_read_second;
    @(posedge clk) disable iff (!rst_n)
      rd_en && sel == dsg_pkg::DSG_SEL_SECOND_LATCH |=>
      prdata[SW-1:0] == (($past(second_dir_ff) & $past(second_latch_ff)) |
        (~$past(second_dir_ff) & $past(second_pin_in)));
  endproperty
  a_read_second: assert property (p_read_second)
    else $error("second port read mixes wrong");

  property p_first_dir_read;
    @(posedge clk) disable iff (!rst_n)
      rd_en && sel == dsg_pkg::DSG_SEL_FIRST_DIR |=>
      prdata == 32'($past(first_dir_ff));
  endproperty
  a_first_dir_read: assert property (p_first_dir_read)
    else $error("first direction read wrong");

  property p_second_dir_read;
    @(posedge clk) disable iff (!rst_n)
      rd_en && sel == dsg_pkg::DSG_SEL_SECOND_DIR |=>
      prdata == 32'($past(second_dir_ff));
  endproperty
  a_second_dir_read: assert property (p_second_dir_read)
    else $error("second direction read wrong");

endmodule
